/* src/pmar_pkg.sv */
package pmar_pkg;

  // Register byte offsets on the slave port
  localparam logic [12:0] OFS_CTRL_STATUS = 13'h1004;  // maint_ctrl_status_reg
  localparam logic [12:0] OFS_ADDR_PTR    = 13'h1008;  // maint_addr_pointer_reg
  localparam logic [12:0] OFS_DATA_WIN    = 13'h100c;  // maint_data_window_reg

  // Control/status field positions
  localparam int BIT_START     = 0;
  localparam int BIT_TMR_DIS   = 1;
  localparam int BIT_WRONG_PAR = 4;
  localparam int BIT_IRQ_EN    = 5;
  localparam int BIT_HALT      = 7;
  localparam int ERR_LSB       = 8;

  // Address pointer fields
  localparam int SEC_MSB = 15;
  localparam int SEC_LSB = 14;
  localparam int CS_OOR  = 12;

  // Section select codes
  localparam logic [1:0] SEC_CS_LOW = 2'h0;
  localparam logic [1:0] SEC_CS_MID = 2'h1;
  localparam logic [1:0] SEC_CS_TOP = 2'h2;
  localparam logic [1:0] SEC_EEPROM = 2'h3;

  // Store sizes
  localparam int CS_WORDS = 4096;
  localparam int EE_BYTES = 8192;

  // Reset values
  localparam logic        RST_HALT      = 1'b0;
  localparam logic        RST_IRQ_EN    = 1'b0;
  localparam logic        RST_WRONG_PAR = 1'b0;
  localparam logic        RST_TMR_DIS   = 1'b0;
  localparam logic [15:0] RST_ADDR_PTR  = 16'h0000;

  // Initialize pulse length
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int INIT_PULSE_NS     = 16;
  localparam int INIT_PULSE_CYCLES =
    (INIT_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] INIT_CNT_LAST = 4'(INIT_PULSE_CYCLES - 1);

  // Hardware error flags, bit 15 down to bit 8
  typedef struct packed {
    logic bp_par;        // Backplane parity on own master cycle
    logic ucode_par;     // ucode_store_parity_flag
    logic int_bus_par;   // internal_bus parity
    logic tx_buf_par;    // tx_buffer_parity_flag
    logic link_par;      // link_bus_parity_flag
    logic map_err;       // error_valid_code on map cycle
    logic chip_bus_par;  // interface_chip_bus read parity
    logic bus_tmo;       // backplane bus timeout
  } pmar_err_t;

  // Software control bits
  typedef struct packed {
    logic halt;
    logic irq_en;
    logic wrong_par;
    logic tmr_dis;
  } pmar_ctrl_t;

  // Initialize pulse sequencer
  typedef enum logic [0:0] {
    PMAR_IDLE  = 1'b0,
    PMAR_PULSE = 1'b1
  } pmar_init_t;

endpackage

/* src/pmar_sticky_flag.sv */
`timescale 1ns/100ps
`default_nettype none

// Sticky hardware error bit; only a reset clears it
module pmar_sticky_flag (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  output logic      flag_o
);

  logic flag_q;  // Held flag
  logic flag_d;  // Next flag

  // Once set, held for software and microcode to inspect
  always_comb begin
    flag_d = flag_q | set_i;
  end

  // Register stage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule

`default_nettype wire

/* src/pmar_regs.sv */
// Operation
// - Backplane master parity sets flag and fault
// - Store parity flags only while sequencer runs and port is initialized
// - Internal bus parity sets flag and fault
// - Transmit buffer parity flags, aborts, faults
// - Link bus parity flags; microcode raises fault
// - Error-valid code on map sets flag, fault
// - Interface chip read parity sets flag, fault
// - Bus timeout signal sets timeout flag
// - Halt stops sequencer; resume unless powering up or faulted
// - Wrong parity: even parity, fault no halt
// - Timer disable blocks timer interrupts
// - Start gives initialize pulse, reads zero
// - Address writable only uninitialized; kept on start
// - Store 48-bit words, 16-bit sections; EEPROM bytes
// - Address advances after data writes only
// - Section advances; word after top section
// - EEPROM write bumps low fourteen bits
// - Section code picks store slice or EEPROM
// - Bank, word and EEPROM byte address decode
// - Data access only uninitialized and halted
// - Fault enters uninitialized, halts unless wrong parity, raises event
`timescale 1ns/100ps
`default_nettype none

module pmar_regs (
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // Register slave port
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire logic [12:0]         reg_addr_i,
  input  wire logic [31:0]         reg_wdata_i,
  output logic      [31:0]         reg_rdata_o,
  output logic                     reg_rvalid_o,
  // Error event pulses; bus_tmo field unused, see timeout pin
  input  wire pmar_pkg::pmar_err_t err_evt_i,
  input  wire logic                backplane_timeout_signal_n_i,
  input  wire logic                ucode_fault_i,
  input  wire logic                port_init_exit_i,
  input  wire logic                powerup_busy_i,
  // Sequencer fetch port
  input  wire logic [11:0]         ucode_addr_i,
  output logic      [47:0]         ucode_word_o,
  // Status and control out
  output logic                     seq_run_o,
  output logic                     init_pulse_o,
  output logic                     tx_abort_o,
  output logic                     int_bus_even_par_o,
  output logic                     timer_irq_en_o,
  output logic                     maint_irq_en_o,
  output logic                     hw_fault_flag_o,
  output logic                     port_uninit_o,
  output logic                     fault_event_o
);

  // Storage arrays
  logic [47:0] cs_mem [pmar_pkg::CS_WORDS];  // Control store words
  logic [7:0]  ee_mem [pmar_pkg::EE_BYTES];  // EEPROM bytes

  // State
  pmar_pkg::pmar_ctrl_t ctrl_q, ctrl_d;      // Software control bits
  pmar_pkg::pmar_err_t  err_q;               // Sticky error flags
  pmar_pkg::pmar_err_t  err_set;             // Flag set events
  pmar_pkg::pmar_init_t init_st_q, init_st_d;
  logic [3:0]  init_cnt_q, init_cnt_d;       // Pulse cycle count
  logic [15:0] addr_q, addr_d;               // Address pointer
  logic        fault_q, fault_d;             // hw_fault_flag
  logic        uninit_q, uninit_d;           // Port uninitialized
  logic        event_q, event_d;             // Fault rise pulse
  logic        abort_q, abort_d;             // Transmit abort pulse
  logic [31:0] rdata_q, rdata_d;             // Read answer
  logic        rvalid_q, rvalid_d;
  logic [47:0] uword_q;                      // Fetched word

  // Decoded strobes
  logic        wr_ctrl, wr_addr, wr_data, rd_ctrl, rd_data;
  logic        data_ok;                      // Data window open
  logic        start_req;                    // Start bit written 1
  logic        init_pulse;                   // Initialize active
  logic        fault_set;                    // Any direct fault cause
  logic [1:0]  sec;                          // Section select
  logic        cs_oor;                       // Store address out of range
  logic        seq_run;

  // Address decode for the slave port
  always_comb begin
    wr_ctrl = 1'b0;
    wr_addr = 1'b0;
    wr_data = 1'b0;
    rd_ctrl = 1'b0;
    rd_data = 1'b0;
    if (reg_addr_i == pmar_pkg::OFS_CTRL_STATUS) begin
      wr_ctrl = reg_wr_i;
      rd_ctrl = reg_rd_i;
    end else if (reg_addr_i == pmar_pkg::OFS_ADDR_PTR) begin
      wr_addr = reg_wr_i;
    end else if (reg_addr_i == pmar_pkg::OFS_DATA_WIN) begin
      wr_data = reg_wr_i;
      rd_data = reg_rd_i;
    end
  end

  assign data_ok   = uninit_q & ctrl_q.halt;
  assign start_req = wr_ctrl & reg_wdata_i[pmar_pkg::BIT_START];
  assign sec       = addr_q[pmar_pkg::SEC_MSB:pmar_pkg::SEC_LSB];
  assign cs_oor    = addr_q[pmar_pkg::CS_OOR];

  // Sequencer runs unless halted, powering up or stopped by a fault
  always_comb begin
    seq_run = ~ctrl_q.halt & ~powerup_busy_i
            & ~(fault_q & ~ctrl_q.wrong_par);
  end

  // Error set causes; store parity is masked when the sequencer is stopped or the port is uninitialized
  always_comb begin
    err_set              = err_evt_i;
    err_set.bus_tmo      = ~backplane_timeout_signal_n_i;
    err_set.ucode_par    = err_evt_i.ucode_par & seq_run & ~uninit_q;
  end

  // One sticky cell per hardware error bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_err
      pmar_sticky_flag u_flag (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .set_i   (err_set[gi]),
        .flag_o  (err_q[gi])
      );
    end
  endgenerate

  // Direct fault causes; link parity and timeout are left to microcode
  always_comb begin
    fault_set = err_set.bp_par
              | err_set.ucode_par
              | err_set.int_bus_par
              | err_set.tx_buf_par
              | err_set.map_err
              | err_set.chip_bus_par
              | ucode_fault_i;
  end

  // Software control bits; start is not stored
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.halt      = reg_wdata_i[pmar_pkg::BIT_HALT];
      ctrl_d.irq_en    = reg_wdata_i[pmar_pkg::BIT_IRQ_EN];
      ctrl_d.wrong_par = reg_wdata_i[pmar_pkg::BIT_WRONG_PAR];
      ctrl_d.tmr_dis   = reg_wdata_i[pmar_pkg::BIT_TMR_DIS];
    end
  end

  // Initialize pulse sequencer; a start during a pulse is dropped
  always_comb begin
    init_st_d  = init_st_q;
    init_cnt_d = init_cnt_q;
    init_pulse = 1'b0;
    case (init_st_q)
      pmar_pkg::PMAR_IDLE: begin
        if (start_req) begin
          init_st_d  = pmar_pkg::PMAR_PULSE;
          init_cnt_d = 4'h0;
        end
      end
      pmar_pkg::PMAR_PULSE: begin
        init_pulse = 1'b1;
        init_cnt_d = init_cnt_q + 4'h1;
        if (init_cnt_q == pmar_pkg::INIT_CNT_LAST) begin
          init_st_d = pmar_pkg::PMAR_IDLE;
        end
      end
      default: begin
        init_st_d = pmar_pkg::PMAR_IDLE;
      end
    endcase
  end

  // Fault and port state; a fresh fault beats the initialize clear
  always_comb begin
    fault_d  = (fault_q & ~init_pulse) | fault_set;
    uninit_d = (uninit_q & ~port_init_exit_i) | init_pulse | fault_set;
    event_d  = fault_set & ~fault_q;
    abort_d  = err_set.tx_buf_par;
  end

  // Address pointer write and post-write advance
  always_comb begin
    addr_d = addr_q;
    if (wr_addr && uninit_q) begin
      addr_d = reg_wdata_i[15:0];
    end else if (wr_data && data_ok) begin
      if (sec == pmar_pkg::SEC_EEPROM) begin
        addr_d[13:0] = addr_q[13:0] + 14'h1;
      end else if (sec == pmar_pkg::SEC_CS_TOP) begin
        addr_d[15:14] = pmar_pkg::SEC_CS_LOW;
        addr_d[12:0]  = addr_q[12:0] + 13'h1;
      end else begin
        addr_d[15:14] = sec + 2'h1;
      end
    end
  end

  // Read answer; closed window and unmapped offsets read zero
  always_comb begin
    rdata_d  = 32'h0000_0000;
    rvalid_d = reg_rd_i;
    if (rd_ctrl) begin
      rdata_d[15:8]                    = err_q;
      rdata_d[pmar_pkg::BIT_HALT]      = ctrl_q.halt;
      rdata_d[pmar_pkg::BIT_IRQ_EN]    = ctrl_q.irq_en;
      rdata_d[pmar_pkg::BIT_WRONG_PAR] = ctrl_q.wrong_par;
      rdata_d[pmar_pkg::BIT_TMR_DIS]   = ctrl_q.tmr_dis;            // Start reads zero
    end else if (rd_data && data_ok) begin
      if (sec == pmar_pkg::SEC_EEPROM) begin
        rdata_d[7:0] = ee_mem[addr_q[12:0]];
      end else if (!cs_oor) begin
        if (sec == pmar_pkg::SEC_CS_LOW) begin
          rdata_d[15:0] = cs_mem[addr_q[11:0]][15:0];
        end else if (sec == pmar_pkg::SEC_CS_MID) begin
          rdata_d[15:0] = cs_mem[addr_q[11:0]][31:16];
        end else begin
          rdata_d[15:0] = cs_mem[addr_q[11:0]][47:32];
        end
      end
    end
  end

  // Register stage for all control state
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_q     <= '{halt: pmar_pkg::RST_HALT, irq_en: pmar_pkg::RST_IRQ_EN,
                      wrong_par: pmar_pkg::RST_WRONG_PAR, tmr_dis: pmar_pkg::RST_TMR_DIS};
      init_st_q  <= pmar_pkg::PMAR_IDLE;
      init_cnt_q <= 4'h0;
      addr_q     <= pmar_pkg::RST_ADDR_PTR;
      fault_q    <= 1'b0;
      uninit_q   <= 1'b1;
      event_q    <= 1'b0;
      abort_q    <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rvalid_q   <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      init_st_q  <= init_st_d;
      init_cnt_q <= init_cnt_d;
      addr_q     <= addr_d;
      fault_q    <= fault_d;
      uninit_q   <= uninit_d;
      event_q    <= event_d;
      abort_q    <= abort_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
    end
  end

  // Store writes take only the low half; upper data bits are dropped
  always_ff @(posedge clock_i) begin
    if (wr_data && data_ok) begin
      if (sec == pmar_pkg::SEC_EEPROM) begin
        ee_mem[addr_q[12:0]] <= reg_wdata_i[7:0];
      end else if (!cs_oor) begin
        if (sec == pmar_pkg::SEC_CS_LOW) begin
          cs_mem[addr_q[11:0]][15:0] <= reg_wdata_i[15:0];
        end else if (sec == pmar_pkg::SEC_CS_MID) begin
          cs_mem[addr_q[11:0]][31:16] <= reg_wdata_i[15:0];
        end else begin
          cs_mem[addr_q[11:0]][47:32] <= reg_wdata_i[15:0];
        end
      end
    end
  end

  // Sequencer fetch, one cycle latency; no reset on the store path
  always_ff @(posedge clock_i) begin
    uword_q <= cs_mem[ucode_addr_i];
  end

  assign reg_rdata_o        = rdata_q;
  assign reg_rvalid_o       = rvalid_q;
  assign ucode_word_o       = uword_q;
  assign seq_run_o          = seq_run;
  assign init_pulse_o       = init_pulse;
  assign tx_abort_o         = abort_q;
  assign int_bus_even_par_o = ctrl_q.wrong_par;
  assign timer_irq_en_o     = ~ctrl_q.tmr_dis;
  assign maint_irq_en_o     = ctrl_q.irq_en;
  assign hw_fault_flag_o    = fault_q;
  assign port_uninit_o      = uninit_q;
  assign fault_event_o      = event_q;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_start_pulse_len: assert property (start_req && init_st_q == pmar_pkg::PMAR_IDLE
    |=> init_pulse_o [*4] ##1 !init_pulse_o) else $error("initialize pulse length wrong");
  a_start_reads_zero: assert property (rd_ctrl |=> reg_rvalid_o && !reg_rdata_o[0])
    else $error("start bit read back as one");
  a_timeout_flag: assert property (!backplane_timeout_signal_n_i |=> err_q.bus_tmo)
    else $error("timeout flag not set");
  a_fault_direct: assert property (err_evt_i.bp_par || err_evt_i.map_err
    |=> hw_fault_flag_o && port_uninit_o) else $error("fault not raised");
  a_link_no_fault: assert property (err_evt_i.link_par && !fault_set && !fault_q
    && !init_pulse |=> err_q.link_par && !hw_fault_flag_o) else $error("link parity faulted");
  a_store_par_gate: assert property (uninit_q && !err_q.ucode_par
    |=> !err_q.ucode_par) else $error("store parity set while uninitialized");
  a_tx_abort: assert property (err_evt_i.tx_buf_par |=> tx_abort_o && err_q.tx_buf_par)
    else $error("transmit abort missing");
  a_halt_stops: assert property (ctrl_q.halt |-> !seq_run_o)
    else $error("sequencer runs while halted");
  a_wrong_par_run: assert property (fault_q && ctrl_q.wrong_par && !ctrl_q.halt
    && !powerup_busy_i |-> seq_run_o) else $error("fault halted despite wrong parity");
  a_addr_locked: assert property (!uninit_q && !port_init_exit_i |=> $stable(addr_q))
    else $error("address changed while initialized");
  a_ee_advance: assert property (wr_data && data_ok && sec == pmar_pkg::SEC_EEPROM
    |=> addr_q == {pmar_pkg::SEC_EEPROM, 14'($past(addr_q[13:0]) + 14'h1)})
    else $error("EEPROM address advance wrong");
  a_cs_top_wrap: assert property (wr_data && data_ok && sec == pmar_pkg::SEC_CS_TOP
    |=> sec == pmar_pkg::SEC_CS_LOW && addr_q[12:0] == 13'($past(addr_q[12:0]) + 13'h1))
    else $error("store word advance wrong");
  a_read_no_adv: assert property (rd_data && !reg_wr_i |=> $stable(addr_q))
    else $error("address advanced on read");
  // Closed window answers, but with zeros only
  a_closed_read_zero: assert property (rd_data && !data_ok
    |=> reg_rvalid_o && reg_rdata_o == 32'h0000_0000) else $error("closed window leaked data");
  // First fault raises the event pulse and leaves the port uninitialized
  a_fault_event: assert property (fault_set && !fault_q
    |=> fault_event_o && port_uninit_o) else $error("fault event missing");

  c_start_pulse: cover property (init_st_q == pmar_pkg::PMAR_PULSE ##4 !init_pulse_o);
  c_ee_write: cover property (wr_data && data_ok && sec == pmar_pkg::SEC_EEPROM);
  c_cs_top_write: cover property (wr_data && data_ok && sec == pmar_pkg::SEC_CS_TOP);
  c_fault_event: cover property (fault_event_o);
  c_closed_read: cover property (rd_data && !data_ok);

endmodule

`default_nettype wire

/* sim/pmar_host.sv */
`timescale 1ns/100ps
`default_nettype none

// Host software stand-in on the register slave port
module pmar_host (
  input  wire logic        clock_i,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [12:0]      reg_addr_o,
  output logic [31:0]      reg_wdata_o,
  input  wire logic [31:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i
);
  int gap;  // Extra idle cycles, a slow host when above zero

  // Quiet bus at time zero
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 13'h0000;
    reg_wdata_o = 32'h00000000;
    gap         = 0;
  end

  // Idle cycles keep changing so a stale value never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock_i);
      #1;
      reg_addr_o  = ~reg_addr_o;
      reg_wdata_o = ~reg_wdata_o;
    end
  endtask

  // One write; at least one idle edge first so strobes never merge
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    idle(gap);
    // Fresh time step, so no signal is set twice with the idle toggle
    @(posedge clock_i);
    #1;
    reg_addr_o  = a;
    reg_wdata_o = (a == pmar_pkg::OFS_DATA_WIN) ? {16'h0000, d[15:0]} : d;
    reg_wr_o    = 1'b1;
    @(posedge clock_i);
    #1;
    reg_wr_o    = 1'b0;
  endtask

  // One read; answer is taken one edge after the strobe
  task automatic rd(input logic [12:0] a, output logic [31:0] d);
    idle(gap);
    @(posedge clock_i);
    #1;
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(posedge clock_i);
    #1;
    reg_rd_o   = 1'b0;
    d          = reg_rvalid_i ? reg_rdata_i : 32'hxxxxxxxx;
  endtask
endmodule

`default_nettype wire

/* sim/port_maintenance_access_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none

module port_maintenance_access_regs_test;
  logic                clock_i, rst_i, wr, rd, rvalid;
  logic [12:0]         addr, a;
  logic [31:0]         wdata, rdata, r;
  pmar_pkg::pmar_err_t err;
  logic                tmo_n, ufault, iexit, pbusy, fx;
  logic [11:0]         uaddr, w;
  logic [47:0]         uword;
  logic                run, initp, txab, evenp, tmren, irqen, fault, uninit, fevt;
  logic [15:0]         d [4];
  int                  miscompares, samples_checked, seed, i, j, s;

  // Host on the far side
  pmar_host pmar_host_i (.clock_i(clock_i), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

  pmar_regs pmar_regs_i (.clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .err_evt_i(err), .backplane_timeout_signal_n_i(tmo_n), .ucode_fault_i(ufault),
    .port_init_exit_i(iexit), .powerup_busy_i(pbusy), .ucode_addr_i(uaddr),
    .ucode_word_o(uword), .seq_run_o(run), .init_pulse_o(initp), .tx_abort_o(txab),
    .int_bus_even_par_o(evenp), .timer_irq_en_o(tmren), .maint_irq_en_o(irqen),
    .hw_fault_flag_o(fault), .port_uninit_o(uninit), .fault_event_o(fevt));

  // 250 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // Pointer value from section code and low address
  function automatic logic [31:0] ptr(input logic [1:0] sec, input logic [12:0] la);
    return {16'h0000, sec, 1'b0, la};
  endfunction

  // Flag pattern for one event bit
  function automatic logic [7:0] flag_exp(input int b);
    return 8'h01 << b;
  endfunction

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Inputs move 1 ns after the edge
  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end

  initial begin
    seed = 32'h0fad2d86;
    miscompares = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    err = '0;
    tmo_n = 1'b1;
    ufault = 1'b0;
    iexit = 1'b0;
    pbusy = 1'b1;
    uaddr = 12'h000;
    repeat (6) tick();
    rst_i = 1'b0;
    chk(uninit, 1'b1);
    chk(run, 1'b0);
    pbusy = 1'b0;
    tick();
    chk(run, 1'b1);
    // Halt, interrupts, wrong parity, timers off, start
    pmar_host_i.wr(pmar_pkg::OFS_CTRL_STATUS, 32'h000000b3);
    for (i = 0; i < 4; i++) begin
      chk(initp, 1'b1);
      tick();
    end
    chk(initp, 1'b0);
    chk(run, 1'b0);
    chk(tmren, 1'b0);
    chk(evenp, 1'b1);
    chk(irqen, 1'b1);
    pmar_host_i.rd(pmar_pkg::OFS_CTRL_STATUS, r);
    chk(r[15:0], 16'h00b2);
    // Control store words in banks 0..2, slow host on later rounds
    for (i = 0; i < 3; i++) begin
      pmar_host_i.gap = i;
      w = 12'($random(seed));
      w[11:10] = 2'(i);
      foreach (d[k]) d[k] = 16'($random(seed));
      pmar_host_i.wr(pmar_pkg::OFS_ADDR_PTR, ptr(pmar_pkg::SEC_CS_LOW, {1'b0, w}));
      foreach (d[k]) pmar_host_i.wr(pmar_pkg::OFS_DATA_WIN, {16'($random(seed)), d[k]});
      uaddr = w;
      tick();
      chk(uword, {d[2], d[1], d[0]});
      for (s = 0; s < 3; s++) begin
        pmar_host_i.wr(pmar_pkg::OFS_ADDR_PTR, ptr(2'(s), {1'b0, w}));
        repeat (2) begin
          pmar_host_i.rd(pmar_pkg::OFS_DATA_WIN, r);
          chk(r[15:0], d[s]);
        end
      end
      pmar_host_i.wr(pmar_pkg::OFS_ADDR_PTR, ptr(pmar_pkg::SEC_CS_LOW, {1'b0, w + 12'h001}));
      pmar_host_i.rd(pmar_pkg::OFS_DATA_WIN, r);
      chk(r[15:0], d[3]);
    end
    pmar_host_i.gap = 0;
    // Out-of-range store address reads zero
    pmar_host_i.wr(pmar_pkg::OFS_ADDR_PTR, ptr(pmar_pkg::SEC_CS_LOW, 13'h1000));
    pmar_host_i.rd(pmar_pkg::OFS_DATA_WIN, r);
    chk(r[15:0], 16'h0000);
    // Two EEPROM bytes in a row; even start avoids carry past bit 12
    a = 13'($random(seed));
    a[0] = 1'b0;
    pmar_host_i.wr(pmar_pkg::OFS_ADDR_PTR, ptr(pmar_pkg::SEC_EEPROM, a));
    for (s = 0; s < 2; s++) pmar_host_i.wr(pmar_pkg::OFS_DATA_WIN, {24'h000000, d[s][7:0]});
    for (s = 1; s >= 0; s--) begin
      pmar_host_i.wr(pmar_pkg::OFS_ADDR_PTR, ptr(pmar_pkg::SEC_EEPROM, a + 13'(s)));
      pmar_host_i.rd(pmar_pkg::OFS_DATA_WIN, r);
      chk(r[7:0], d[s][7:0]);
    end
    // Window shut with halt clear
    pmar_host_i.wr(pmar_pkg::OFS_CTRL_STATUS, 32'h00000000);
    chk(tmren, 1'b1);
    chk(evenp, 1'b0);
    chk(irqen, 1'b0);
    chk(run, 1'b1);
    pmar_host_i.wr(pmar_pkg::OFS_DATA_WIN, {16'h0000, ~d[0]});
    pmar_host_i.rd(pmar_pkg::OFS_DATA_WIN, r);
    chk(r[15:0], 16'h0000);
    // Leave uninitialized: pointer and data writes are dropped
    iexit = 1'b1;
    tick();
    iexit = 1'b0;
    chk(uninit, 1'b0);
    pmar_host_i.wr(pmar_pkg::OFS_ADDR_PTR, ptr(pmar_pkg::SEC_EEPROM, 13'h0000));
    pmar_host_i.wr(pmar_pkg::OFS_CTRL_STATUS, 32'h00000080);
    pmar_host_i.wr(pmar_pkg::OFS_DATA_WIN, {16'h0000, ~d[0]});
    pmar_host_i.wr(pmar_pkg::OFS_CTRL_STATUS, 32'h00000081);
    repeat (5) tick();
    chk(uninit, 1'b1);
    pmar_host_i.rd(pmar_pkg::OFS_DATA_WIN, r);
    chk(r[7:0], d[0][7:0]);
    pmar_host_i.rd(13'h1010, r);
    chk(r, 32'h00000000);
    // Each error event from a fresh reset; round 0 is store parity while uninitialized
    for (j = 0; j < 8; j++) begin
      i = (j == 0) ? 6 : j;
      rst_i = 1'b1;
      tick();
      rst_i = 1'b0;
      if (j != 0) begin
        iexit = 1'b1;
        tick();
        iexit = 1'b0;
      end
      fx = (j != 0) && (i != 3);
      err = pmar_pkg::pmar_err_t'(flag_exp(i));
      tick();
      err = '0;
      chk(fault, fx);
      chk(fevt, fx);
      chk(uninit, fx || (j == 0));
      chk(txab, i == 4);
      pmar_host_i.rd(pmar_pkg::OFS_CTRL_STATUS, r);
      chk(r[15:8], (j == 0) ? 8'h00 : flag_exp(i));
      if (i == 3) begin
        ufault = 1'b1;
        tick();
        ufault = 0;
        chk(fault, 1'b1);
      end
    end
    // Timeout sets its flag only; then fault, wrong parity and start
    rst_i = 1'b1;
    tick();
    rst_i = 1'b0;
    tmo_n = 1'b0;
    tick();
    tmo_n = 1'b1;
    chk(fault, 1'b0);
    ufault = 1'b1;
    tick();
    ufault = 1'b0;
    chk(run, 1'b0);
    pmar_host_i.wr(pmar_pkg::OFS_CTRL_STATUS, 32'h00000010);
    chk(run, 1'b1);
    pmar_host_i.wr(pmar_pkg::OFS_CTRL_STATUS, 32'h00000011);
    repeat (5) tick();
    chk(fault, 1'b0);
    pmar_host_i.rd(pmar_pkg::OFS_CTRL_STATUS, r);
    chk(r[15:0], 16'h0110);
    complete_run();
  end
endmodule

`default_nettype wire
